// file: spm_pkg.sv
package spm_pkg;
   // ==========================================================
   // Register map (byte addresses on the Wishbone bus).
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS  = 4'h4;
   localparam logic [3:0] ADDR_DATA    = 4'h8;
   localparam logic [3:0] ADDR_CPU     = 4'hc;

   // ==========================================================
   // Control register fields.
   localparam int CR_IRQ_EN  = 7;
   localparam int CR_PORT_EN = 6;
   localparam int CR_MASTER  = 4;
   localparam int CR_IDLE    = 3;
   localparam int CR_PHASE   = 2;
   localparam int CR_RATE1   = 1;
   localparam int CR_RATE0   = 0;
   localparam logic [7:0] CR_RESET = 8'h00;

   // ==========================================================
   // Status register fields.
   localparam int SR_DONE  = 7;
   localparam int SR_WRITE_COLLISION_FLAG  = 6;
   localparam int SR_MODE_FAULT_FLAG  = 4;

   // ==========================================================
   // Timing: bits per byte, half-period dividers in CLOCK cycles.
   // The fastest rate keeps four cycles per half period, because MISO passes a
   // three-stage synchroniser and must settle before the next capture edge.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [6:0] HALF_DIV0     = 7'h04;
   localparam logic [6:0] HALF_DIV1     = 7'h08;
   localparam logic [6:0] HALF_DIV2     = 7'h10;
   localparam logic [6:0] HALF_DIV3     = 7'h40;

   typedef enum logic [1:0] {
      SPM_IDLE = 2'b00,
      SPM_RUN  = 2'b01,
      SPM_LAST = 2'b11
   } spm_state_t;

   typedef struct packed {
      logic       sck;
      logic       ss_n;
      logic       mosi;
      logic       miso;
   } spm_pins_t;

   typedef struct packed {
      logic [31:0] dat;
      logic [3:0]  adr;
      logic        cyc;
      logic        stb;
      logic        we;
   } spm_wb_req_t;

   typedef struct packed {
      spm_state_t st;
      logic [7:0] ctrl;
      logic       done;
      logic       write_collision_flag;
      logic       mode_fault_flag;
      logic       sr_seen;
      logic       cpu_mask;
      logic [7:0] shreg;
      logic [7:0] rxbuf;
      logic [3:0] nbit;
      logic       edge_odd;
      logic [6:0] div;
      logic       sck_o;
      logic       out_bit;
      logic [2:0] sync_sck;
      logic [2:0] sync_ss;
      logic [2:0] sync_mosi;
      logic [2:0] sync_miso;
      logic       sck_f;
      logic       ss_f;
      logic       ack;
      logic [31:0] rdat;
      logic       irq;
   } spm_regs_t;
endpackage

// file: spm_port.sv
`timescale 1ns/1ps
// How it works
// - Bytes shift MSB first, full duplex.
// - Exactly eight clock pulses per byte.
// - Master drives SCK and MOSI, samples MISO.
// - Master data write loads shifter, starts.
// - Done flag; interrupt if enabled and unmasked.
// - Received byte copied to buffer at end.
// - Done clears: status access then data access.
// - Data writes ignored while done, until status read.
// - Master needs SS high to stay enabled.
// - Slave uses external SCK, ignores rate bits.
// - Slave inputs MOSI, shifts data out MISO.
// - Slave starts on master clock edges.
// - Idle level sets resting SCK level.
// - Phase set: second edge captures first bit.
// - Phase clear: first edge captures first bit.
// - Master presents data half period early.
// - Phase clear: slave SS low blocks data writes.
// - Phase set: no collision across bytes.
// - Unselected slave leaves shared lines alone.
// - Busy data write dropped, collision flag set.
// - SS low in master raises mode fault.
// - Mode fault clears: status then control write.
module spm_port
   import spm_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        SCK_I,
   output logic             SCK_O,
   output logic             SCK_OE,
   input  wire logic        MOSI_I,
   output logic             MOSI_O,
   output logic             MOSI_OE,
   input  wire logic        MISO_I,
   output logic             MISO_O,
   output logic             MISO_OE,
   input  wire logic        SS_N_I,
   output logic             IRQ
);
   import spm_pkg::*;

   spm_regs_t q;
   spm_regs_t d;
   spm_pins_t pin;

   // ==========================================================
   // Helpers.
   function automatic logic [6:0] half_div(input logic [1:0] rate);
      case (rate)
         2'b00:   half_div = HALF_DIV0;
         2'b01:   half_div = HALF_DIV1;
         2'b10:   half_div = HALF_DIV2;
         default: half_div = HALF_DIV3;
      endcase
   endfunction

   // Synchronised inputs: for SCK and SS, stage 3 becomes the filtered level when stages 2 and 3 agree; MOSI and MISO take stage 3 directly.
   assign pin.sck  = q.sck_f;
   assign pin.ss_n = q.ss_f;
   assign pin.mosi = q.sync_mosi[2];
   assign pin.miso = q.sync_miso[2];

   logic acc, wr, rd, ad_ctl, ad_st, ad_dat, ad_cpu, en, mst, ph, idl;
   logic sedge;
   // A filtered SCK change: stages 2 and 3 agree on a level the filter has not taken yet.
   assign sedge  = q.sync_sck[1] == q.sync_sck[2] && q.sync_sck[2] != pin.sck;
   assign acc    = WB_CYC_I && WB_STB_I && !q.ack;
   assign wr     = acc && WB_WE_I && WB_SEL_I[0];
   assign rd     = acc && !WB_WE_I;
   assign ad_ctl = WB_ADR_I == ADDR_CONTROL;
   assign ad_st  = WB_ADR_I == ADDR_STATUS;
   assign ad_dat = WB_ADR_I == ADDR_DATA;
   assign ad_cpu = WB_ADR_I == ADDR_CPU;
   assign en     = q.ctrl[CR_PORT_EN];
   assign mst    = q.ctrl[CR_MASTER];
   assign ph     = q.ctrl[CR_PHASE];
   assign idl    = q.ctrl[CR_IDLE];

   // ==========================================================
   // Next-state logic.
   // Slave SCK edges are seen after a three-stage synchroniser, which is why the
   // external clock must stay at or below a quarter-ish of CLOCK in practice.
   always_comb begin
      logic edge_now;
      logic take;
      logic mwrite;
      edge_now = 1'b0;
      take     = 1'b0;
      mwrite   = 1'b0;
      d        = q;
      d.ack    = acc;
      d.sync_sck  = {q.sync_sck[1:0], SCK_I};
      d.sync_ss   = {q.sync_ss[1:0], SS_N_I};
      d.sync_mosi = {q.sync_mosi[1:0], MOSI_I};
      d.sync_miso = {q.sync_miso[1:0], MISO_I};
      if (q.sync_sck[1] == q.sync_sck[2]) d.sck_f = q.sync_sck[2];
      if (q.sync_ss[1] == q.sync_ss[2]) d.ss_f = q.sync_ss[2];

      // Register reads.
      if (rd) begin
         if (ad_ctl) d.rdat = {24'h0, q.ctrl};
         else if (ad_st) d.rdat = {24'h0, q.done, q.write_collision_flag, 1'b0, q.mode_fault_flag, 4'h0};
         else if (ad_dat) d.rdat = {24'h0, q.rxbuf};
         else if (ad_cpu) d.rdat = {31'h0, q.cpu_mask};
         else d.rdat = 32'h0;
      end
      // A status access arms the clearing sequences.
      if (acc && ad_st) d.sr_seen = q.done || q.write_collision_flag || q.mode_fault_flag;
      if (acc && ad_dat && q.sr_seen) begin
         d.done    = 1'b0;
         d.write_collision_flag    = 1'b0;
         d.sr_seen = 1'b0;
      end
      if (wr && ad_cpu) d.cpu_mask = WB_DAT_I[0];
      if (wr && ad_ctl) begin
         if (q.mode_fault_flag && q.sr_seen) begin
            d.mode_fault_flag    = 1'b0;
            d.sr_seen = 1'b0;
            d.ctrl    = WB_DAT_I[7:0];
         end else if (q.mode_fault_flag) begin
            // Enable and master cannot be set while a fault stands.
            d.ctrl = WB_DAT_I[7:0] & ~8'h50;
         end else begin
            d.ctrl = WB_DAT_I[7:0];
         end
      end

      // Data writes: done blocks until status read, busy or slave-selected with phase clear collides.
      if (wr && ad_dat) begin
         if (q.done && !(acc && q.sr_seen)) begin
            // Ignored.
         end else if (q.st != SPM_IDLE || (!mst && !pin.ss_n && !ph)) begin
            d.write_collision_flag = 1'b1;
         end else begin
            d.shreg   = WB_DAT_I[7:0];
            d.out_bit = WB_DAT_I[7];
            mwrite    = en && mst;
         end
      end

      // Shifting engine.
      case (q.st)
         SPM_IDLE: begin
            d.sck_o    = idl;
            d.nbit     = 4'h0;
            d.edge_odd = 1'b0;
            d.div      = half_div({q.ctrl[CR_RATE1], q.ctrl[CR_RATE0]});
            if (mwrite) begin
               d.st = SPM_RUN;
            end else if (en && !mst && !pin.ss_n && sedge) begin
               // First slave edge starts the byte and is handled at once.
               d.st      = SPM_RUN;
               d.out_bit = q.shreg[7];
               edge_now  = 1'b1;
            end
         end
         SPM_RUN: begin
            if (mst) begin
               if (q.div == 7'h01) begin
                  d.div   = half_div({q.ctrl[CR_RATE1], q.ctrl[CR_RATE0]});
                  d.sck_o = !q.sck_o;
                  edge_now = 1'b1;
               end else begin
                  d.div = q.div - 7'h01;
               end
            end else begin
               edge_now = sedge;
            end
         end
         SPM_LAST: begin
            d.st   = SPM_IDLE;
            d.done = 1'b1;
            d.rxbuf = q.shreg;
         end
         default: d.st = SPM_IDLE;
      endcase

      // Edge handling: odd edges capture when phase clear, even edges when set.
      // The byte ends on the sixteenth edge in both phases, so no ninth pulse appears.
      // A slave shows its next bit right after the capture edge: its view of the
      // shift edge comes through the synchroniser too late for the next capture.
      if (edge_now) begin
         take = (q.edge_odd == ph);
         d.edge_odd = !q.edge_odd;
         if (take) begin
            d.shreg = {q.shreg[6:0], mst ? pin.miso : pin.mosi};
            d.nbit  = q.nbit + 4'h1;
            if (!mst) d.out_bit = q.shreg[6];
            if (ph && q.nbit + 4'h1 == BITS_PER_BYTE) d.st = SPM_LAST;
         end else begin
            d.out_bit = q.shreg[7];
            if (!ph && q.nbit == BITS_PER_BYTE) d.st = SPM_LAST;
         end
      end
      // The clock rests at its idle level once the byte is finished.
      if (q.st == SPM_LAST) d.sck_o = idl;

      // Mode fault or disable aborts everything.
      if (en && mst && !pin.ss_n) begin
         d.mode_fault_flag = 1'b1;
         d.ctrl[CR_PORT_EN] = 1'b0;
         d.ctrl[CR_MASTER]  = 1'b0;
         d.st = SPM_IDLE;
      end
      if (!en) d.st = SPM_IDLE;
      if (!mst && pin.ss_n && q.st == SPM_RUN) d.st = SPM_IDLE;

      d.irq = q.ctrl[CR_IRQ_EN] && !q.cpu_mask && (q.done || q.mode_fault_flag);
   end

   // ==========================================================
   // State register.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         q <= '0;
         q.sync_ss <= 3'h7;
         q.ss_f    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs are straight register copies, gated with enable and role.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
         SCK_O <= 1'b0;
         SCK_OE <= 1'b0;
         MOSI_O <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_O <= 1'b0;
         MISO_OE <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         WB_ACK_O <= d.ack;
         WB_DAT_O <= d.rdat;
         SCK_O   <= d.sck_o;
         SCK_OE  <= d.ctrl[CR_PORT_EN] && d.ctrl[CR_MASTER];
         MOSI_O  <= d.out_bit;
         MOSI_OE <= d.ctrl[CR_PORT_EN] && d.ctrl[CR_MASTER];
         MISO_O  <= d.out_bit;
         // Unselected slave keeps MISO released.
         MISO_OE <= d.ctrl[CR_PORT_EN] && !d.ctrl[CR_MASTER] && !d.ss_f;
         IRQ     <= d.irq;
      end
   end

   // ==========================================================
   // Checks.
   a_ack_one_cycle: assert property (@(posedge CLOCK) disable iff (RST)
      WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
   a_mode_fault_flag_drops_en: assert property (@(posedge CLOCK) disable iff (RST)
      (en && mst && !pin.ss_n) |=> (q.mode_fault_flag && !q.ctrl[CR_PORT_EN])) else $error("mode fault");
   a_done_buffer: assert property (@(posedge CLOCK) disable iff (RST)
      (q.st == SPM_LAST) |=> (q.done && q.rxbuf == $past(q.shreg))) else $error("buffer");
   a_idle_level: assert property (@(posedge CLOCK) disable iff (RST)
      (q.st == SPM_IDLE && $past(q.st) == SPM_IDLE) |-> q.sck_o == $past(idl))
      else $error("idle level");
   a_disabled_idle: assert property (@(posedge CLOCK) disable iff (RST)
      !en |=> q.st == SPM_IDLE) else $error("disabled transfer");
   a_miso_quiet: assert property (@(posedge CLOCK) disable iff (RST)
      (q.ss_f && !$past(q.ss_f)) |=> !MISO_OE) else $error("miso driven");
   a_bit_count: assert property (@(posedge CLOCK) disable iff (RST)
      q.nbit <= BITS_PER_BYTE) else $error("bit count");
   a_irq_gate: assert property (@(posedge CLOCK) disable iff (RST)
      q.cpu_mask && $past(q.cpu_mask) |-> !IRQ) else $error("irq unmasked");
endmodule // spm_port

// file: spm_far_dev.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side serial device: a plain byte-wide slave with a select.
module spm_far_dev (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   input  wire logic       clock_idle_level,
   input  wire logic       clock_phase_select,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx
);
   logic mo = 1'h0;
   int   idx = 0;

   // With phase clear the first bit must already wait on the line at select.
   always @(negedge ss_n) begin
      idx = 0;
      rx = 8'h00;
      if (!clock_phase_select) begin
         mo = tx[7];
         idx = 1;
      end
   end

   // Capture on the edge picked by phase and polarity, shift on the other.
   always @(sck) begin
      if (!ss_n && sck == ~(clock_idle_level ^ clock_phase_select)) begin
         rx = {rx[6:0], mosi};
      end else if (!ss_n && idx < 8) begin
         mo = tx[7 - idx];
         idx = idx + 1;
      end
   end

   // Deselected, the line flips away so a late sample cannot match by luck.
   assign miso = ss_n ? ~mo : mo;
endmodule // spm_far_dev

// file: spm_port_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench: master in four modes, mode fault, slave.
module spm_port_tb;
   import spm_pkg::*;
   logic        clock = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rq;
   logic        ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq;
   logic        tb_sck = 1'h0, tb_mosi = 1'h0, ss_n = 1'h1, far_ss_n = 1'h1;
   logic        clock_idle_level = 1'h0, clock_phase_select = 1'h0, far_miso;
   logic [7:0]  far_tx = 8'h00, far_rx, got;
   int          fail_count = 0, n_tests = 0;
   wire         sck_w  = sck_oe ? sck_o : tb_sck;
   wire         mosi_w = mosi_oe ? mosi_o : tb_mosi;
   wire         miso_w = miso_oe ? miso_o : far_miso;

   spm_port dut_u (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_SEL_I(4'hf), .WB_ADR_I(adr), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCK_I(sck_w), .SCK_O(sck_o),
      .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
      .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_n),
      .IRQ(irq));
   spm_far_dev far_u (.sck(sck_w), .mosi(mosi_w), .ss_n(far_ss_n), .clock_idle_level(clock_idle_level),
      .clock_phase_select(clock_phase_select), .tx(far_tx), .miso(far_miso), .rx(far_rx));

   // A 20 ns clock.
   initial begin
      forever #10 clock = ~clock;
   end

   // ==========================================================
   // Shared tasks.
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One classic cycle; the request holds until ack is seen at an edge.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int k;
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (k = 0; k < 50; k++) begin
         @(posedge clock);
         if (ack === 1'h1) break;
      end
      q = rdat;
      if (k == 50) begin
         fail_count++;
         complete_run();
      end
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      @(posedge clock);
   endtask

   task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
      wb(1'h0, a, 32'h0, rq);
      chk(what, rq, exp);
   endtask

   // Polling status also arms the clearing of the done flag.
   task automatic wait_done;
      int k;
      for (k = 0; k < 3000; k++) begin
         wb(1'h0, ADDR_STATUS, 32'h0, rq);
         if (rq[SR_DONE] === 1'h1) break;
      end
      if (k == 3000) begin
         fail_count++;
         complete_run();
      end
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      rdchk("control", ADDR_CONTROL, {24'h0, CR_RESET});
      rdchk("status", ADDR_STATUS, 32'h0);
      rdchk("unmapped", 4'h2, 32'h0);
      chk("irq", irq, 1'h0);
      $display("test reset done");
   endtask

   // Each mode also picks a different rate, and a second write collides.
   task automatic t_master(input logic [1:0] m);
      clock_idle_level <= m[0];
      clock_phase_select <= m[1];
      tb_sck <= m[0];
      wb(1'h1, ADDR_CONTROL, {24'h0, 8'hd0 | {4'h0, m[0], m[1], m}}, rq);
      chk("sck idle", sck_w, m[0]);
      far_tx <= 8'h3c + {6'h0, m};
      far_ss_n <= 1'h0;
      @(posedge clock);
      wb(1'h1, ADDR_DATA, {24'h0, 8'ha5 ^ {6'h0, m}}, rq);
      wb(1'h1, ADDR_DATA, 32'h0, rq);
      wait_done();
      chk("irq", irq, 1'h1);
      rdchk("status", ADDR_STATUS, 32'hc0);
      rdchk("data", ADDR_DATA, {24'h0, 8'h3c + {6'h0, m}});
      chk("far rx", far_rx, 8'ha5 ^ {6'h0, m});
      rdchk("status", ADDR_STATUS, 32'h0);
      chk("irq", irq, 1'h0);
      chk("sck idle", sck_w, m[0]);
      far_ss_n <= 1'h1;
      $display("test master mode %0d done", m);
   endtask

   task automatic t_fault;
      wb(1'h1, ADDR_CONTROL, 32'hd0, rq);
      ss_n <= 1'h0;
      repeat (8) @(posedge clock);
      ss_n <= 1'h1;
      repeat (4) @(posedge clock);
      chk("irq", irq, 1'h1);
      rdchk("status", ADDR_STATUS, 32'h10);
      rdchk("control", ADDR_CONTROL, 32'h80);
      wb(1'h1, ADDR_CONTROL, 32'h80, rq);
      rdchk("status", ADDR_STATUS, 32'h0);
      chk("irq", irq, 1'h0);
      $display("test fault done");
   endtask

   // The bench plays master at 160 ns per bit; the interrupt is masked.
   task automatic t_slave;
      logic [7:0] mb;
      mb = 8'hc3;
      clock_idle_level <= 1'h0;
      clock_phase_select <= 1'h0;
      tb_sck <= 1'h0;
      wb(1'h1, ADDR_CONTROL, 32'hc0, rq);
      wb(1'h1, ADDR_DATA, 32'h5a, rq);
      wb(1'h1, ADDR_CPU, 32'h1, rq);
      ss_n <= 1'h0;
      tb_mosi <= mb[7];
      repeat (4) @(posedge clock);
      wb(1'h1, ADDR_DATA, 32'hff, rq);
      for (int i = 0; i < 8; i++) begin
         repeat (4) @(posedge clock);
         tb_sck <= 1'h1;
         got = {got[6:0], miso_w};
         repeat (4) @(posedge clock);
         tb_sck <= 1'h0;
         mb = {mb[6:0], 1'h0};
         tb_mosi <= mb[7];
      end
      repeat (8) @(posedge clock);
      ss_n <= 1'h1;
      chk("slave out", got, 8'h5a);
      chk("irq", irq, 1'h0);
      rdchk("status", ADDR_STATUS, 32'hc0);
      rdchk("data", ADDR_DATA, 32'hc3);
      wb(1'h1, ADDR_CPU, 32'h0, rq);
      $display("test slave done");
   endtask

   // Main sequence: reset for 20 cycles, then every scenario in turn.
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      t_reset();
      for (int i = 0; i < 4; i++) begin
         t_master(i[1:0]);
      end
      t_fault();
      t_slave();
      complete_run();
   end
endmodule // spm_port_tb
